// *** src/sepc_defs.svh ***
// Purpose: Constants of the serial memory protection controller
// Assumes: 50 MHz ref_clk_i
// Notes:   Opcodes, status bit positions, sizes and write-cycle timing
`ifndef SEPC_DEFS_SVH
`define SEPC_DEFS_SVH
`define SEPC_OP_SET_LATCH    8'h06
`define SEPC_OP_CLEAR_LATCH  8'h04
`define SEPC_OP_STATUS_READ  8'h05
`define SEPC_OP_STATUS_WRITE 8'h01
`define SEPC_OP_ARRAY_READ   8'h03
`define SEPC_OP_ARRAY_WRITE  8'h02
`define SEPC_ST_PIN_EN       7
`define SEPC_ST_GUARD_HI     3
`define SEPC_ST_GUARD_LO     2
`define SEPC_ST_LATCH        1
`define SEPC_ST_BUSY         0
`define SEPC_ADDR_W          14
`define SEPC_PAGE_BYTES      32
`define SEPC_WRITE_NS        5000000
`define SEPC_CLK_NS          20
`define SEPC_WRITE_CYCLES    (`SEPC_WRITE_NS / `SEPC_CLK_NS)
`define SEPC_FIFO_DEPTH      16
`endif

// *** src/sepc_pkg.sv ***
// Purpose: Types of the serial memory protection controller
// Assumes: sepc_defs.svh holds the numbers
// Notes:   Sequencer phases of one selected frame
package sepc_pkg;
    typedef enum logic [2:0] {
        SEPC_IDLE   = 3'b000,
        SEPC_OPCODE = 3'b001,
        SEPC_ADDR   = 3'b010,
        SEPC_RDATA  = 3'b011,
        SEPC_WDATA  = 3'b100,
        SEPC_SDATA  = 3'b101,
        SEPC_IGNORE = 3'b110
    } sepc_phase_e;
endpackage

// *** src/sepc_fifo.sv ***
// Purpose: Holds no logic of its own
// Assumes: The page write buffer module sepc_fifo sits beside the controller
// Notes:   One design file carries all the logic

// *** src/sepc_ctrl.sv ***
// Purpose: Slave command and protection logic of a 16K x 8 serial memory
// Assumes: Link pins are asynchronous and pass two flip-flops first
// Notes:   Guard and pin-enable bits and the array outlive reset
`timescale 1ns/1ns
`include "sepc_defs.svh"
module sepc_ctrl #(
    parameter int WRITE_CYCLES = `SEPC_WRITE_CYCLES,
    parameter int FIFO_DEPTH   = `SEPC_FIFO_DEPTH
) (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic cs_n_i,
    input  wire logic sck_i,
    input  wire logic si_i,
    output logic      so_o,
    output logic      so_oe_o,
    input  wire logic wp_n_i,
    input  wire logic hold_n_i,
    output logic      standby_o
);
    import sepc_pkg::*;
    localparam int AW = `SEPC_ADDR_W;
    localparam int FW = AW + 8;
    // Timer field is 23 bits wide
    if (WRITE_CYCLES < 1 || WRITE_CYCLES > 8388607 || FIFO_DEPTH < 2) begin
        $error("bad parameters");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1;
    logic [4:0] sync2;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1 <= 5'h1f;
            sync2 <= 5'h1f;
        end else begin
            sync1 <= {cs_n_i, sck_i, si_i, wp_n_i, hold_n_i};
            sync2 <= sync1;
        end
    end
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic hold_n;
    assign {cs_n, sck, si, wp_n, hold_n} = sync2;

    // ------------------------------------------------------------
    // Array storage and write buffer
    // ------------------------------------------------------------
    logic [7:0]    mem [1 << AW];
    logic [FW-1:0] fifo_in;
    logic          fifo_in_valid;
    logic          fifo_in_ready;
    logic [FW-1:0] fifo_out;
    logic          fifo_out_valid;
    logic          fifo_pop;
    logic          fifo_flush;

    typedef struct packed {
        logic              armed;
        logic              cs_q;
        logic              sck_q;
        logic              paused;
        sepc_phase_e       phase;
        logic [4:0]        bitcnt;
        logic [15:0]       shreg;
        logic [7:0]        opcode;
        logic [AW-1:0]     addr;
        logic [7:0]        txbyte;
        logic              byte_done;
        logic              wp_fell;
        logic              latch;
        logic              busy;
        logic              commit_arr;
        logic [7:0]        new_status;
        logic              status_pend;
        logic [5:0]        nbytes;
        logic [22:0]       timer;
        logic              so;
        logic              so_oe;
    } sepc_state_s;

    sepc_state_s st;
    sepc_state_s next_st;
    logic [7:0]  status_view;
    logic        protected_addr;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_rise;
    logic        cs_fall;
    logic        active;
    logic        nv_load;
    logic        pin_en = 1'b0;
    logic [1:0]  guard  = 2'b00;

    sepc_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rstn_i      (rstn_i),
        .flush_i     (fifo_flush),
        .in_data_i   (fifo_in),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop)
    );

    // ------------------------------------------------------------
    // Status view and protection map
    // ------------------------------------------------------------
    always_comb begin
        if (st.busy) begin
            status_view = 8'hff;
        end else begin
            status_view = {pin_en, 3'h0, guard, st.latch, 1'b0};
        end
    end

    function automatic logic is_guarded(input logic [1:0] g, input logic [AW-1:0] a);
        unique case (g)
            2'b00: is_guarded = 1'b0;
            2'b01: is_guarded = (a[AW-1:AW-2] == 2'b11);
            2'b10: is_guarded = a[AW-1];
            2'b11: is_guarded = 1'b1;
        endcase
    endfunction

    assign protected_addr = is_guarded(guard, fifo_out[FW-1:8]);
    assign sck_rise       = sck && !st.sck_q && active;
    assign sck_fall       = !sck && st.sck_q && active;
    assign cs_rise        = cs_n && !st.cs_q;
    assign cs_fall        = !cs_n && st.cs_q;
    assign active         = st.armed && !cs_n && !st.paused;
    // Only the first 32 data bytes of a frame are offered to the buffer
    assign fifo_in        = {st.addr, st.shreg[6:0], si};
    assign fifo_in_valid  = sck_rise && st.phase == SEPC_WDATA && st.bitcnt == 5'd7
                            && st.nbytes < 6'(`SEPC_PAGE_BYTES);
    // Drain stalls until the write cycle is committed
    assign fifo_pop       = st.commit_arr && fifo_out_valid;
    assign fifo_flush     = cs_fall;

    always_ff @(posedge ref_clk_i) begin
        if (fifo_pop && !protected_addr) mem[fifo_out[FW-1:8]] <= fifo_out[7:0];
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.cs_q  = cs_n;
        next_st.sck_q = sck;
        // Pause and release only count while the clock is low
        if (!cs_n && !sck) next_st.paused = !hold_n;
        if (cs_fall) begin
            next_st.armed     = 1'b1;
            next_st.phase     = SEPC_OPCODE;
            next_st.bitcnt    = '0;
            next_st.byte_done = 1'b0;
            next_st.wp_fell   = 1'b0;
            next_st.nbytes    = '0;
            next_st.paused    = 1'b0;
        end
        if (!cs_n && st.armed && !wp_n) next_st.wp_fell = 1'b1;
        if (sck_rise) begin
            next_st.shreg     = {st.shreg[14:0], si};
            next_st.bitcnt    = st.bitcnt + 5'd1;
            next_st.byte_done = 1'b0;
            unique case (st.phase)
                SEPC_OPCODE: begin
                    if (st.bitcnt == 5'd7) begin
                        next_st.opcode    = {st.shreg[6:0], si};
                        next_st.bitcnt    = '0;
                        next_st.byte_done = 1'b1;
                        unique case ({st.shreg[6:0], si})
                            `SEPC_OP_ARRAY_READ, `SEPC_OP_ARRAY_WRITE: begin
                                next_st.phase = SEPC_ADDR;
                            end
                            `SEPC_OP_STATUS_READ: begin
                                next_st.phase  = SEPC_RDATA;
                                next_st.txbyte = status_view;
                            end
                            `SEPC_OP_STATUS_WRITE: begin
                                next_st.phase = SEPC_SDATA;
                            end
                            default: begin
                                next_st.phase = SEPC_IGNORE;
                            end
                        endcase
                    end
                end
                SEPC_ADDR: begin
                    if (st.bitcnt == 5'd15) begin
                        next_st.addr   = {st.shreg[AW-2:0], si};
                        next_st.bitcnt = '0;
                        if (st.opcode == `SEPC_OP_ARRAY_READ) begin
                            next_st.phase  = SEPC_RDATA;
                            next_st.txbyte = mem[{st.shreg[AW-2:0], si}];
                        end else begin
                            next_st.phase = SEPC_WDATA;
                        end
                    end
                end
                SEPC_RDATA: begin
                    if (st.bitcnt == 5'd7) begin
                        next_st.bitcnt = '0;
                        if (st.opcode == `SEPC_OP_ARRAY_READ) begin
                            next_st.addr   = st.addr + 1'b1;
                            next_st.txbyte = mem[st.addr + 1'b1];
                        end else begin
                            next_st.txbyte = status_view;
                        end
                    end else begin
                        next_st.txbyte = {st.txbyte[6:0], 1'b0};
                    end
                end
                SEPC_WDATA: begin
                    if (st.bitcnt == 5'd7) begin
                        next_st.bitcnt    = '0;
                        next_st.byte_done = 1'b1;
                        if (st.nbytes < 6'(`SEPC_PAGE_BYTES)) begin
                            next_st.nbytes = st.nbytes + 6'd1;
                        end
                        // Wrap inside the 32-byte page
                        next_st.addr[4:0] = st.addr[4:0] + 5'd1;
                    end
                end
                SEPC_SDATA: begin
                    if (st.bitcnt == 5'd7) begin
                        next_st.new_status = {st.shreg[6:0], si};
                        next_st.byte_done  = 1'b1;
                        next_st.phase      = SEPC_IGNORE;
                    end
                end
                SEPC_IDLE, SEPC_IGNORE: begin
                    next_st.bitcnt = st.bitcnt;
                end
                default: begin
                    next_st.phase = SEPC_IGNORE;
                end
            endcase
        end
        // Output shifts after each fall, MSB first
        if (sck_fall && st.phase == SEPC_RDATA) begin
            next_st.so    = st.txbyte[7];
            next_st.so_oe = 1'b1;
        end
        if (cs_n || !st.armed || st.phase != SEPC_RDATA) next_st.so_oe = 1'b0;
        if (cs_rise && st.armed) begin
            next_st.phase = SEPC_IDLE;
            // Commands only take effect on a clean byte boundary
            if (st.byte_done && !st.busy) begin
                if (st.opcode == `SEPC_OP_SET_LATCH && st.phase == SEPC_IGNORE) begin
                    next_st.latch = 1'b1;
                end else if (st.opcode == `SEPC_OP_CLEAR_LATCH
                             && st.phase == SEPC_IGNORE) begin
                    next_st.latch = 1'b0;
                end else if (st.opcode == `SEPC_OP_ARRAY_WRITE && st.phase == SEPC_WDATA
                             && st.latch && st.nbytes != 6'd0) begin
                    next_st.busy       = 1'b1;
                    next_st.commit_arr = 1'b1;
                    next_st.timer      = 23'(WRITE_CYCLES);
                end else if (st.opcode == `SEPC_OP_STATUS_WRITE && st.phase == SEPC_IGNORE
                             && st.latch
                             && !(pin_en && (st.wp_fell || !wp_n))) begin
                    next_st.busy        = 1'b1;
                    next_st.status_pend = 1'b1;
                    next_st.timer       = 23'(WRITE_CYCLES);
                end
            end
        end
        if (st.busy) begin
            if (st.timer <= 23'd1) begin
                next_st.busy       = 1'b0;
                next_st.latch      = 1'b0;
                next_st.commit_arr = 1'b0;
                next_st.status_pend = 1'b0;
            end else begin
                next_st.timer = st.timer - 23'd1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // Latch and busy start clear; nonvolatile bits live outside
            st <= '{phase: SEPC_IDLE, cs_q: 1'b1, sck_q: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // Nonvolatile cells: no reset, so a power cycle keeps them
    assign nv_load = st.busy && st.timer <= 23'd1 && st.status_pend;
    always_ff @(posedge ref_clk_i) begin
        if (nv_load) begin
            pin_en <= st.new_status[`SEPC_ST_PIN_EN];
            guard  <= {st.new_status[`SEPC_ST_GUARD_HI], st.new_status[`SEPC_ST_GUARD_LO]};
        end
    end

    assign so_o      = st.so;
    assign so_oe_o   = st.so_oe;
    assign standby_o = cs_n && !st.busy;
endmodule

// ------------------------------------------------------------
// Page write data buffer, valid/ready on both sides
// ------------------------------------------------------------
module sepc_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             flush_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
        $error("DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;
    assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
endmodule

// *** tb/sepc_ctrl_monitor.sv ***
// Purpose: Port-level checks of the serial memory protection controller
// Assumes: One clock domain, link pins pass two sync stages in the design
// Notes:   Bounds allow for sync stages plus edge detection
`timescale 1ns/1ns
module sepc_ctrl_monitor (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic cs_n_i,
    input  wire logic sck_i,
    input  wire logic si_i,
    input  wire logic so_o,
    input  wire logic so_oe_o,
    input  wire logic wp_n_i,
    input  wire logic hold_n_i,
    input  wire logic standby_o
);
    logic [3:0] since_fall;
    logic [4:0] rises;
    logic       seen_sel;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            since_fall <= 4'hf;
            rises      <= 5'h00;
            seen_sel   <= 1'b0;
        end else begin
            since_fall <= $fell(sck_i) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hf};
            rises      <= cs_n_i ? 5'h00 : rises + {4'h0, $rose(sck_i) && hold_n_i};
            seen_sel   <= seen_sel | $fell(cs_n_i);
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_float;   cs_n_i [*5] |-> !so_oe_o;                        endproperty
    property p_release; $rose(cs_n_i) |-> ##[1:6] !so_oe_o;              endproperty
    property p_awake;   !cs_n_i [*4] |-> !standby_o;                     endproperty
    property p_sel_oe;  $rose(so_oe_o) |-> !cs_n_i;                      endproperty
    property p_edge;    so_oe_o && $past(so_oe_o) && $changed(so_o) |-> since_fall <= 4'h5;
    endproperty
    property p_first;   !seen_sel |-> !so_oe_o;                          endproperty
    property p_hold;    !hold_n_i [*8] |-> $stable({so_o, so_oe_o});     endproperty
    property p_len;     $rose(so_oe_o) |-> rises >= 5'h08;               endproperty
    a_float: assert property (p_float) else $error("output driven while deselected");
    a_release: assert property (p_release) else $error("output not released");
    a_awake: assert property (p_awake) else $error("standby while selected");
    a_sel_oe: assert property (p_sel_oe) else $error("drive began while deselected");
    a_edge: assert property (p_edge) else $error("output changed away from clock fall");
    a_first: assert property (p_first) else $error("output before first select");
    a_hold: assert property (p_hold) else $error("output moved during pause");
    a_len: assert property (p_len) else $error("reply before eight opcode bits");
    c_read:  cover property ($rose(so_oe_o));
    c_pause: cover property (!hold_n_i && !cs_n_i);
    c_sel:   cover property ($fell(cs_n_i));
endmodule

bind sepc_ctrl sepc_ctrl_monitor u_mon (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
    .sck_i(sck_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .wp_n_i(wp_n_i),
    .hold_n_i(hold_n_i), .standby_o(standby_o));

// *** tb/sepc_host_model.sv ***
// Purpose: Host side of the serial link, mode 0, 160 ns bit time
// Assumes: 50 MHz ref_clk_i, tasks end on a clock edge
// Notes:   Serial clock stands low between frames
`timescale 1ns/1ns
module sepc_host_model (
    input  wire logic ref_clk_i,
    input  wire logic so_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    output logic      hold_n_o
);
    initial begin
        cs_n_o   = 1'b1;
        sck_o    = 1'b0;
        si_o     = 1'b0;
        hold_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic select();
        tick(1);
        cs_n_o <= 1'b0;
        tick(4);
    endtask
    // Released data line shows the inverse so a stale level never matches
    task automatic deselect();
        tick(4);
        cs_n_o <= 1'b1;
        si_o   <= ~si_o;
        tick(8);
    endtask
    // Sends tx[7] downward for n bits; reply sampled late in the high phase
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            si_o  <= tx[i];
            tick(4);
            sck_o <= 1'b1;
            tick(4);
            rx[i] = so_i;
            sck_o <= 1'b0;
        end
    endtask
    // Pause entered and left with the clock low; clock and data toggle meanwhile
    task automatic pause(input int n);
        tick(4);
        hold_n_o <= 1'b0;
        repeat (n) begin
            tick(4);
            sck_o <= ~sck_o;
            si_o  <= ~si_o;
        end
        tick(4);
        hold_n_o <= 1'b1;
        tick(4);
    endtask
endmodule

// *** tb/sepc_ctrl_tb.sv ***
// Purpose: Self-checking bench of the serial memory protection controller
// Assumes: Write cycle shortened to 1000 clocks
// Notes:   Status polled until the busy flag clears
`timescale 1ns/1ns
`include "sepc_defs.svh"
module sepc_ctrl_tb;
    logic ref_clk_i, rstn_i, wp_n_i, cs_n, sck, si, so, so_oe, hold_n, standby, so_line;
    logic [7:0] r, s;
    int n_errors = 0;
    int tests_run = 0;
    sepc_ctrl #(.WRITE_CYCLES(1000), .FIFO_DEPTH(16)) dut (.ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
        .wp_n_i(wp_n_i), .hold_n_i(hold_n), .standby_o(standby));
    // Undriven output line reads as the inverse of its last bit
    assign so_line = so_oe ? so : ~so;
    sepc_host_model host (.ref_clk_i(ref_clk_i), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck),
        .si_o(si), .hold_n_o(hold_n));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        host.select();
        host.xfer(op, 8, r);
        host.deselect();
    endtask
    task automatic status_read_cmd(output logic [7:0] st);
        host.select();
        host.xfer(`SEPC_OP_STATUS_READ, 8, r);
        host.xfer(8'h00, 8, st);
        host.deselect();
    endtask
    task automatic wait_idle();
        logic [7:0] st;
        st = 8'hff;
        for (int i = 0; i < 40 && st[0] !== 1'b0; i++) status_read_cmd(st);
        chk(8'h00, {7'h00, st[0]});
    endtask
    task automatic wr_stat(input logic [7:0] v);
        cmd(`SEPC_OP_SET_LATCH);
        host.select();
        host.xfer(`SEPC_OP_STATUS_WRITE, 8, r);
        host.xfer(v, 8, r);
        host.deselect();
    endtask
    task automatic raw_write(input logic [7:0] d, input int nb);
        host.xfer(`SEPC_OP_ARRAY_WRITE, 8, r);
        host.xfer(8'h00, 8, r);
        host.xfer(8'h00, 8, r);
        host.xfer(d, nb, r);
    endtask
    task automatic wr_arr(input logic [15:0] a, input logic [7:0] d [3], input int n);
        cmd(`SEPC_OP_SET_LATCH);
        host.select();
        host.xfer(`SEPC_OP_ARRAY_WRITE, 8, r);
        host.xfer(a[15:8], 8, r);
        host.xfer(a[7:0], 8, r);
        for (int i = 0; i < n; i++) host.xfer(d[i], 8, r);
        host.deselect();
        wait_idle();
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e0, e1, input int n);
        host.select();
        host.xfer(`SEPC_OP_ARRAY_READ, 8, r);
        host.xfer(a[15:8], 8, r);
        host.xfer(a[7:0], 8, r);
        host.xfer(8'h00, 8, s);
        chk(e0, s);
        if (n > 1) begin
            host.xfer(8'h00, 8, s);
            chk(e1, s);
        end
        host.deselect();
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_status_basics();
        status_read_cmd(s);
        chk(8'h00, s);
        cmd(`SEPC_OP_SET_LATCH);
        status_read_cmd(s);
        chk(8'h02, s);
        cmd(`SEPC_OP_CLEAR_LATCH);
        status_read_cmd(s);
        chk(8'h00, s);
    endtask
    task automatic t_array_basics();
        wr_arr(16'h3000, '{8'h11, 8'h00, 8'h00}, 1);
        wr_arr(16'h001f, '{8'ha1, 8'hb2, 8'hc3}, 3);
        rd_chk(16'hc000, 8'hb2, 8'hc3, 2);
        rd_chk(16'h001f, 8'ha1, 8'h00, 1);
        status_read_cmd(s);
        chk(8'h00, s);
    endtask
    task automatic t_refusals();
        host.select();
        raw_write(8'hee, 8);
        host.deselect();
        status_read_cmd(s);
        chk(8'h00, s);
        cmd(`SEPC_OP_SET_LATCH);
        host.select();
        raw_write(8'hee, 5);
        host.deselect();
        status_read_cmd(s);
        chk(8'h02, s);
        cmd(`SEPC_OP_CLEAR_LATCH);
        host.select();
        host.xfer(`SEPC_OP_SET_LATCH, 8, r);
        raw_write(8'hee, 8);
        host.deselect();
        status_read_cmd(s);
        chk(8'h00, {7'h00, s[0]});
        rd_chk(16'h0000, 8'hb2, 8'h00, 1);
    endtask
    task automatic t_status_write();
        wr_stat(8'h8c);
        chk(8'h00, {7'h00, standby});
        status_read_cmd(s);
        chk(8'hff, s);
        wait_idle();
        chk(8'h01, {7'h00, standby});
        status_read_cmd(s);
        chk(8'h8c, s);
        cmd(`SEPC_OP_SET_LATCH);
        host.select();
        host.xfer(`SEPC_OP_STATUS_WRITE, 8, r);
        wp_n_i <= 1'b0;
        host.xfer(8'h00, 8, r);
        wp_n_i <= 1'b1;
        host.deselect();
        status_read_cmd(s);
        chk(8'h8e, s);
        wp_n_i <= 1'b0;
        wr_stat(8'h00);
        status_read_cmd(s);
        chk(8'h8e, s);
        wp_n_i <= 1'b1;
        wr_stat(8'h04);
        wait_idle();
        status_read_cmd(s);
        chk(8'h04, s);
    endtask
    task automatic t_protect();
        rstn_i <= 1'b0;
        host.tick(5);
        rstn_i <= 1'b1;
        host.tick(3);
        status_read_cmd(s);
        chk(8'h04, s);
        wr_arr(16'h3000, '{8'h22, 8'h00, 8'h00}, 1);
        wr_arr(16'h2fff, '{8'h33, 8'h00, 8'h00}, 1);
        rd_chk(16'h2fff, 8'h33, 8'h11, 2);
    endtask
    task automatic t_pause();
        host.select();
        host.xfer(`SEPC_OP_STATUS_READ, 4, r);
        host.pause(6);
        host.xfer(8'h50, 4, r);
        host.pause(2);
        host.xfer(8'h00, 8, s);
        host.deselect();
        chk(8'h04, s);
    endtask
    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic close_out();
        $display("Summary: %0d checks, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        rstn_i = 1'b0;
        wp_n_i = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        host.tick(3);
        t_status_basics();
        t_array_basics();
        t_refusals();
        t_status_write();
        t_protect();
        t_pause();
        close_out();
    end
    // Expected run is about 14k clocks; the limit of 50k clocks allows over three times that
    initial begin
        #1000000;
        n_errors++;
        close_out();
    end
endmodule
